// *** include/ptx_pkg.sv ***
// Purpose: Shared constants of the parallel-to-serial link transmitter
// Assumes: 100 MHz system clock, pixel clock sampled as a plain input
// Notes:   Register map, frame layout, timing counts and encodings
package ptx_pkg;

    // System clock and pixel clock limits
    localparam longint CLK_FREQ_HZ    = 100_000_000;
    localparam longint PIX_MIN_HZ     = 5_000_000;
    localparam longint PIX_MAX_HZ     = 50_000_000;
    localparam longint STOP_FREQ_HZ   = 3_000_000;

    // Frame layout: one embedded clock/polarity bit plus 27 payload bits
    localparam int     DATA_BITS      = 24;
    localparam int     CTRL_BITS      = 3;
    localparam int     PAYLOAD_BITS   = DATA_BITS + CTRL_BITS;
    localparam int     FRAME_BITS     = 28;
    localparam int     SHUFFLE_STEP   = 5;

    // Line rate bounds that follow from the pixel clock range
    localparam longint LINE_MIN_BPS   = PIX_MIN_HZ * FRAME_BITS;
    localparam longint LINE_MAX_BPS   = PIX_MAX_HZ * FRAME_BITS;

    // Longest pixel period before the clock counts as stopped
    localparam int     STOP_CYCLES    = int'(CLK_FREQ_HZ / STOP_FREQ_HZ);
    localparam int     LOCK_EDGES     = 4;

    // Scrambler seed and feedback taps (27-bit LFSR)
    localparam logic [26:0] SCR_SEED  = 27'h5a5a5a5;
    localparam logic [26:0] SCR_TAPS  = 27'h4000023;

    // Register byte offsets
    localparam logic [3:0] CTRL_OFF   = 4'h0;
    localparam logic [3:0] STATUS_OFF = 4'h4;
    localparam logic [3:0] FRAMES_OFF = 4'h8;

    // Control register fields
    localparam int     CTRL_SWING     = 0;
    localparam int     CTRL_EMPH_LO   = 1;
    localparam int     CTRL_EMPH_HI   = 3;
    localparam int     CTRL_EDGE      = 4;
    localparam int     CTRL_OVERRIDE  = 5;
    localparam int     CTRL_WIDTH     = 6;
    localparam logic [5:0] CTRL_RESET = 6'h10;

    // Status register fields
    localparam int     STAT_SLEEP     = 0;
    localparam int     STAT_LOCKING   = 1;
    localparam int     STAT_RUNNING   = 2;

    // De-emphasis codes
    localparam logic [2:0] EMPH_OFF   = 3'h0;
    localparam logic [2:0] EMPH_3DB   = 3'h1;
    localparam logic [2:0] EMPH_6DB   = 3'h2;
    localparam logic [2:0] EMPH_9DB   = 3'h3;
    localparam logic [2:0] EMPH_12DB  = 3'h4;

    // AXI responses
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;

    // Link states, one-hot
    typedef enum logic [2:0] {
        ST_SLEEP = 3'h1,
        ST_LOCK  = 3'h2,
        ST_RUN   = 3'h4
    } ptx_state_e;

endpackage : ptx_pkg

// *** verilog/ptx_shifter.sv ***
// Purpose: Frame shift register, sends a loaded frame MSB first
// Assumes: One bit per system clock, load only while idle
// Notes:   Output holds the last bit after a frame ends
`timescale 1ns/1ps
module ptx_shifter #(
    parameter int WIDTH = 28
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] frame,
    output logic                  bit_out,
    output logic                  busy
);
    localparam int CNT_W = $clog2(WIDTH + 1);
    localparam int WIDTH_M1 = WIDTH - 1;

    if (WIDTH < 2) begin : g_bad_width
        $error("ptx_shifter: WIDTH must be at least 2");
    end

    logic [WIDTH-1:0] sr_q, sr_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             bit_q, bit_d;

    // Next shift state
    always_comb begin
        sr_d  = sr_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        if (load && cnt_q == '0) begin
            sr_d  = {frame[WIDTH-2:0], 1'b0};
            bit_d = frame[WIDTH-1];
            cnt_d = CNT_W'(WIDTH - 1);
        end else if (cnt_q != '0) begin
            bit_d = sr_q[WIDTH-1];
            sr_d  = {sr_q[WIDTH-2:0], 1'b0};
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Shift registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sr_q  <= '0;
            cnt_q <= '0;
            bit_q <= 1'b0;
        end else begin
            sr_q  <= sr_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
        end
    end

    assign bit_out = bit_q;
    assign busy    = (cnt_q != '0);

    sequence s_load;
        load && !busy;
    endsequence

    property p_frame_len;
        @(posedge clk) disable iff (rst) s_load |=> busy ##WIDTH_M1 !busy;
    endproperty

    // Every frame occupies exactly the full bit count
    chk_frame_length: assert property (p_frame_len) // RL3
        else $error("frame did not last its full bit count");

endmodule : ptx_shifter

// *** verilog/ptx_link_tx.sv ***
// Purpose: Transmit end of an embedded-clock serial link with AXI4-Lite control
// Assumes: PIXEL_CLOCK_IN synchronous to CLK and at most CLK/28
// Notes:   Summary of operation follows
// Summary of operation
// RL1: Each pixel period carries 24 data and 3 control bits on one pair.
// RL2: Line rate spans 140 Mbit/s to 1.4 Gbit/s, following the pixel clock; the code shifts one bit per CLK, a fixed 100 Mbit/s.
// RL3: Each pixel period becomes a 28-bit serial frame.
// RL4: Words are scrambled, then DC-balanced, then bit-shuffled.
// RL5: The receiver locks to any pattern without reference or training.
// RL6: Host clock spreading stays center spread, at most 35 kHz, 2 percent.
// RL7: Swing select high gives increased output level, low gives standard.
// RL8: De-emphasis starts one bit after a transition; off, -3 to -12 dB.
// RL9: System should select high swing whenever de-emphasis is on.
// RL10: Power-down idles the pair at zero differential and resets registers.
// RL11: Pixel clock below 3 MHz counts as stopped; enter sleep.
// RL12: Clock return relocks and resumes; registers kept through sleep.
// RL13: Host holds a stopped pixel clock static low or high.
// RL14: Edge select high captures on rising edge, low on falling.
// RL15: Transmit and receive edge selections are independent.
// RL16: Data enable and both syncs travel encoded within the stream.
// RL17: In 18-bit use six extra general-purpose signals ride along.
// RL18: Both ends use the same matched invertible coding.
// RL19: Pixel clock 5 to 50 MHz; power-down is an async active-low reset. The code needs at least 28 CLK per pixel period.
`timescale 1ns/1ps
module ptx_link_tx
    import ptx_pkg::*;
#(
    parameter int STOP_LIMIT = STOP_CYCLES,
    parameter int LOCK_COUNT = LOCK_EDGES
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        POWER_DOWN_N,
    input  wire logic        PIXEL_CLOCK_IN,
    input  wire logic [23:0] PIXEL_DATA,
    input  wire logic        VIDEO_DATA_ENABLE,
    input  wire logic        HORIZONTAL_SYNC,
    input  wire logic        VERTICAL_SYNC,
    input  wire logic        SWING_SELECT,
    input  wire logic [2:0]  EMPHASIS_LEVEL,
    input  wire logic        CAPTURE_EDGE_SELECT,
    output logic             SER_P,
    output logic             SER_N,
    output logic [27:0]      FRAME_WORD,
    output logic             FRAME_STROBE,
    output logic             SWING_HIGH,
    output logic [2:0]       EMPH_SETTING,
    output logic             EMPH_ACTIVE,
    output logic             SLEEPING,
    input  wire logic [3:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    input  wire logic [3:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);
    localparam int IDLE_W = $clog2(STOP_LIMIT + 1);
    localparam int LOCK_W = $clog2(LOCK_COUNT + 1);

    if (STOP_LIMIT < FRAME_BITS || LOCK_COUNT < 1) begin : g_bad_params
        $error("ptx_link_tx: STOP_LIMIT must cover a frame and LOCK_COUNT be positive");
    end

    // Power-down acts as asynchronous reset of all logic
    logic rst_all;
    assign rst_all = RST | ~POWER_DOWN_N; // RL19 RL10

    // Mapped register test, shared by read and write paths
    function automatic logic is_mapped(input logic [3:0] a);
        is_mapped = (a == CTRL_OFF) || (a == STATUS_OFF) || (a == FRAMES_OFF);
    endfunction : is_mapped

    // Fixed bit shuffle: output i takes input (i*step) mod 27
    function automatic logic [26:0] shuffle(input logic [26:0] v);
        shuffle = '0;
        for (int i = 0; i < PAYLOAD_BITS; i++) begin
            shuffle[i] = v[(i * SHUFFLE_STEP) % PAYLOAD_BITS];
        end
    endfunction : shuffle

    function automatic logic [4:0] ones(input logic [26:0] v);
        ones = '0;
        for (int i = 0; i < PAYLOAD_BITS; i++) begin
            ones = ones + 5'(v[i]);
        end
    endfunction : ones

    // ---------------- Register bus ----------------
    logic [CTRL_WIDTH-1:0] ctrl_q, ctrl_d;
    logic [31:0]           frames_q, frames_d;
    logic                  aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [3:0]            aw_addr_q, aw_addr_d;
    logic [31:0]           w_data_q, w_data_d;
    logic [3:0]            w_strb_q, w_strb_d;
    logic                  bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]            bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]           rdata_q, rdata_d;
    logic                  awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    ptx_state_e            state_q, state_d;
    logic                  frame_load;

    // Write and read channel next state
    always_comb begin
        aw_full_d = aw_full_q;
        aw_addr_d = aw_addr_q;
        w_full_d  = w_full_q;
        w_data_d  = w_data_q;
        w_strb_d  = w_strb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        ctrl_d    = ctrl_q;
        frames_d  = frames_q + 32'(frame_load);
        if (AWVALID && awready_q) begin
            aw_full_d = 1'b1;
            aw_addr_d = AWADDR;
        end
        if (WVALID && wready_q) begin
            w_full_d = 1'b1;
            w_data_d = WDATA;
            w_strb_d = WSTRB;
        end
        if (BVALID && BREADY) begin
            bvalid_d = 1'b0;
        end
        if (aw_full_q && w_full_q && !bvalid_q) begin
            aw_full_d = 1'b0;
            w_full_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLV;
            if (aw_addr_q == CTRL_OFF && w_strb_q[0]) begin
                ctrl_d = w_data_q[CTRL_WIDTH-1:0]; // RL12
            end
        end
        if (RVALID && RREADY) begin
            rvalid_d = 1'b0;
        end
        if (ARVALID && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = is_mapped(ARADDR) ? RESP_OKAY : RESP_SLV;
            case (ARADDR)
                CTRL_OFF:   rdata_d = {26'h0, ctrl_q};
                STATUS_OFF: rdata_d = {29'h0, state_q == ST_RUN, state_q == ST_LOCK, state_q == ST_SLEEP};
                FRAMES_OFF: rdata_d = frames_q;
                default:    rdata_d = 32'h0;
            endcase
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d  = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // Bus registers, loaded with reset values (control with CTRL_RESET) by reset and by power-down
    always_ff @(posedge CLK or posedge rst_all) begin
        if (rst_all) begin
            ctrl_q    <= CTRL_RESET; // RL10
            frames_q  <= 32'h0;
            aw_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_full_q  <= 1'b0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OKAY;
            rdata_q   <= 32'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            frames_q  <= frames_d;
            aw_full_q <= aw_full_d;
            aw_addr_q <= aw_addr_d;
            w_full_q  <= w_full_d;
            w_data_q  <= w_data_d;
            w_strb_q  <= w_strb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
        end
    end

    assign AWREADY = awready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = rvalid_q;
    assign RRESP   = rresp_q;
    assign RDATA   = rdata_q;

    // Settings come from the pins unless the register overrides them
    logic       ovr, swing_eff, edge_eff;
    logic [2:0] emph_raw, emph_eff;
    assign ovr       = ctrl_q[CTRL_OVERRIDE];
    assign swing_eff = ovr ? ctrl_q[CTRL_SWING] : SWING_SELECT; // RL7
    assign edge_eff  = ovr ? ctrl_q[CTRL_EDGE] : CAPTURE_EDGE_SELECT; // RL14 RL15
    assign emph_raw  = ovr ? ctrl_q[CTRL_EMPH_HI:CTRL_EMPH_LO] : EMPHASIS_LEVEL;
    assign emph_eff  = (emph_raw > EMPH_12DB) ? EMPH_OFF : emph_raw; // RL8

    // ---------------- Capture, sleep and lock ----------------
    logic              pix_q;
    logic              cap_edge;
    logic [IDLE_W-1:0] idle_q, idle_d;
    logic [LOCK_W-1:0] lock_q, lock_d;
    logic              stop_hit;

    // Active edge of the sampled pixel clock
    assign cap_edge = edge_eff ? (PIXEL_CLOCK_IN && !pix_q) : (!PIXEL_CLOCK_IN && pix_q); // RL14
    assign stop_hit = !cap_edge && (idle_q == IDLE_W'(STOP_LIMIT - 1)); // RL11 RL13

    // Link state next values
    always_comb begin
        state_d = state_q;
        lock_d  = lock_q;
        idle_d  = cap_edge ? '0 : (stop_hit ? idle_q : idle_q + 1'b1);
        case (state_q)
            ST_SLEEP: begin
                if (cap_edge) begin
                    state_d = ST_LOCK; // RL12
                    lock_d  = '0;
                end
            end
            ST_LOCK: begin
                if (stop_hit) begin
                    state_d = ST_SLEEP;
                end else if (cap_edge) begin
                    if (lock_q == LOCK_W'(LOCK_COUNT - 1)) begin
                        state_d = ST_RUN;
                    end else begin
                        lock_d = lock_q + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (stop_hit) begin
                    state_d = ST_SLEEP; // RL11
                end
            end
            default: state_d = ST_SLEEP;
        endcase
    end

    // Link state registers
    always_ff @(posedge CLK or posedge rst_all) begin
        if (rst_all) begin
            state_q <= ST_SLEEP;
            pix_q   <= 1'b0;
            idle_q  <= '0;
            lock_q  <= '0;
        end else begin
            state_q <= state_d;
            pix_q   <= PIXEL_CLOCK_IN;
            idle_q  <= idle_d;
            lock_q  <= lock_d;
        end
    end

    // ---------------- Encoder ----------------
    logic [26:0]       lfsr_q, lfsr_d;
    logic signed [7:0] rd_q, rd_d;
    logic [27:0]       frame_d;
    logic [26:0]       payload, scr, bal;
    logic signed [7:0] disp;
    logic              inv, sh_busy, sh_bit;

    assign frame_load = (state_q == ST_RUN) && cap_edge && !sh_busy; // RL2 RL3
    // Sync and enable bits ride in the payload; 18-bit use puts GP bits in 23:18
    assign payload = {VERTICAL_SYNC, HORIZONTAL_SYNC, VIDEO_DATA_ENABLE, PIXEL_DATA}; // RL1 RL16 RL17
    assign scr     = payload ^ lfsr_q; // RL4 RL18
    assign disp    = 8'(signed'({3'h0, ones(scr)})) * 8'sd2 + 8'sd2 - 8'sd28;
    assign inv     = (rd_q > 0 && disp > 0) || (rd_q < 0 && disp < 0);
    assign bal     = inv ? ~scr : scr; // RL4
    assign frame_d = {~inv, shuffle(bal)}; // RL4 RL18

    // Scrambler and running disparity next values
    always_comb begin
        lfsr_d = lfsr_q;
        rd_d   = rd_q;
        if (state_q != ST_RUN) begin
            lfsr_d = SCR_SEED;
            rd_d   = 8'sd0;
        end else if (frame_load) begin
            lfsr_d = {lfsr_q[25:0], ^(lfsr_q & SCR_TAPS)};
            rd_d   = inv ? rd_q - disp : rd_q + disp;
        end
    end

    // Encoder registers and frame outputs
    always_ff @(posedge CLK or posedge rst_all) begin
        if (rst_all) begin
            lfsr_q       <= SCR_SEED;
            rd_q         <= 8'sd0;
            FRAME_WORD   <= 28'h0;
            FRAME_STROBE <= 1'b0;
        end else begin
            lfsr_q       <= lfsr_d;
            rd_q         <= rd_d;
            FRAME_WORD   <= frame_load ? frame_d : FRAME_WORD;
            FRAME_STROBE <= frame_load;
        end
    end

    ptx_shifter #(
        .WIDTH (FRAME_BITS)
    ) u_shift (
        .clk     (CLK),
        .rst     (rst_all),
        .load    (frame_load),
        .frame   (frame_d),
        .bit_out (sh_bit),
        .busy    (sh_busy)
    );

    // Line drive: zero differential unless running, de-emphasis after a bit
    always_ff @(posedge CLK or posedge rst_all) begin
        if (rst_all) begin
            SER_P        <= 1'b1;
            SER_N        <= 1'b1;
            SWING_HIGH   <= 1'b0;
            EMPH_SETTING <= EMPH_OFF;
            EMPH_ACTIVE  <= 1'b0;
            SLEEPING     <= 1'b1;
        end else begin
            SER_P        <= (state_q == ST_RUN) ? sh_bit : 1'b1; // RL10 RL1
            SER_N        <= (state_q == ST_RUN) ? ~sh_bit : 1'b1; // RL10 RL1
            SWING_HIGH   <= swing_eff; // RL7
            EMPH_SETTING <= emph_eff; // RL8
            EMPH_ACTIVE  <= (state_q == ST_RUN) && (emph_eff != EMPH_OFF) && (sh_bit == SER_P) && (SER_P != SER_N); // RL8
            SLEEPING     <= (state_d == ST_SLEEP);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (rst_all);

    chk_stop_sleep: assert property (stop_hit && state_q != ST_SLEEP |=> state_q == ST_SLEEP) // RL11
        else $error("stopped clock did not enter sleep");
    chk_zero_diff: assert property (state_q != ST_RUN |=> SER_P && SER_N) // RL10
        else $error("pair not idle while not running");
    chk_diff_pair: assert property ($past(state_q) == ST_RUN |-> SER_N == !SER_P) // RL1
        else $error("pair not complementary while running");
    chk_swing_level: assert property (!$past(rst_all) |-> SWING_HIGH == $past(swing_eff)) // RL7
        else $error("swing output does not follow setting");
    chk_emph_delay: assert property (SER_P != $past(SER_P) |-> !EMPH_ACTIVE) // RL8
        else $error("de-emphasis active in a transition bit");
    chk_rd_bound: assert property (rd_q <= 8'sd28 && rd_q >= -8'sd28) // RL4
        else $error("running disparity out of bounds");
    chk_lock_resume: assert property (state_q == ST_LOCK && cap_edge && !stop_hit // RL12
        && lock_q == LOCK_W'(LOCK_COUNT - 1) && !(aw_full_q && w_full_q)
        |=> state_q == ST_RUN && ctrl_q == $past(ctrl_q))
        else $error("lock did not resume transmission");
    chk_edge_frame: assert property (frame_load |=> FRAME_STROBE ##1 !FRAME_STROBE) // RL14
        else $error("captured edge did not yield one frame strobe");

endmodule : ptx_link_tx

// *** verification/ptx_rx_model.sv ***
// Purpose: Far-end receiver model, turns serial frames back into payload words
// Assumes: Frame bits start one cycle after the strobe, one bit per clock
// Notes:   Counts frame-bit cycles where the two legs are not complementary
`timescale 1ns/1ps
module ptx_rx_model
    import ptx_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   ser_p,
    input  wire logic   ser_n,
    input  wire logic   strobe,
    input  wire logic   sleeping,
    output logic [26:0] word,
    output int          frames,
    output int          pair_err
);
    logic [27:0] sh;
    logic [26:0] lfsr;
    logic [26:0] bal;
    int          cnt;
    // Collect a frame, undo shuffle, balance and scrambling
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt = 0;
            frames = 0;
            pair_err = 0;
            word = '0;
            lfsr = SCR_SEED;
        end else begin
            if (sleeping) lfsr = SCR_SEED;
            if (cnt > 0) begin
                if (ser_n !== ~ser_p) pair_err++;
                sh = {sh[26:0], ser_p};
                cnt--;
                if (cnt == 0) begin
                    for (int i = 0; i < 27; i++) bal[(5 * i) % 27] = sh[i];
                    word = (sh[27] ? bal : ~bal) ^ lfsr;
                    lfsr = {lfsr[25:0], ^(lfsr & SCR_TAPS)};
                    frames++;
                end
            end
            if (strobe) cnt = 28;
        end
    end
endmodule : ptx_rx_model

// *** verification/parallel_to_serial_link_transmitter_bench.sv ***
// Purpose: Self-checking bench of the link transmitter
// Assumes: Pixel clock made here, 55 system clocks per pixel period
// Notes:   Round trip through the receiver model checks the coding
`timescale 1ns/1ps
module parallel_to_serial_link_transmitter_bench import ptx_pkg::*;;
    localparam int STOP = 120;
    logic        clk, rst, pd_n, pclk, v_sync, h_sync, d_en, swing, edge_sel;
    logic [23:0] data;
    logic [2:0]  emph, emph_set;
    logic        ser_p, ser_n, strobe, swing_hi, emph_act, sleeping;
    logic [27:0] frame_word;
    logic [3:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd_v;
    logic [1:0]  bresp, rresp, rsp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [26:0] rx_word;
    int          rx_frames, pair_err, n_fail, checks_done;
    logic [53:0] rows [5] = '{{2{27'h0}}, {2{27'h7ffffff}}, {2{27'h1000000}}, {2{27'h2123456}}, {2{27'h4fedcba}}};

    ptx_link_tx #(.STOP_LIMIT(STOP), .LOCK_COUNT(LOCK_EDGES)) i_dut (
        .CLK(clk), .RST(rst), .POWER_DOWN_N(pd_n), .PIXEL_CLOCK_IN(pclk), .PIXEL_DATA(data),
        .VIDEO_DATA_ENABLE(d_en), .HORIZONTAL_SYNC(h_sync), .VERTICAL_SYNC(v_sync), .SWING_SELECT(swing),
        .EMPHASIS_LEVEL(emph), .CAPTURE_EDGE_SELECT(edge_sel), .SER_P(ser_p), .SER_N(ser_n),
        .FRAME_WORD(frame_word), .FRAME_STROBE(strobe), .SWING_HIGH(swing_hi), .EMPH_SETTING(emph_set),
        .EMPH_ACTIVE(emph_act), .SLEEPING(sleeping), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
        .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
        .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
    ptx_rx_model i_rx (.clk(clk), .rst(rst | ~pd_n), .ser_p(ser_p), .ser_n(ser_n), .strobe(strobe),
        .sleeping(sleeping), .word(rx_word), .frames(rx_frames), .pair_err(pair_err));

    // Free-running system clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task finish_test;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task guard(input int k);
        if (k >= 60) begin
            n_fail++;
            finish_test();
        end
    endtask : guard

    // Write with address and data offered together
    task axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 60);
        bready <= 1'b0;
        rsp = bresp;
        guard(n);
    endtask : axw

    task axr(input logic [3:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 60);
        rready <= 1'b0;
        rd_v = rdata;
        rsp  = rresp;
        guard(n);
    endtask : axr

    // One unspread pixel period; the phase not captured carries the inverted word
    task pix(input logic [26:0] w, input logic fall);
        @(posedge clk);
        {v_sync, h_sync, d_en, data} <= fall ? ~w : w;
        pclk <= 1'b1;
        repeat (17) @(posedge clk);
        {v_sync, h_sync, d_en, data} <= fall ? w : ~w;
        pclk <= 1'b0;
        repeat (37) @(posedge clk);
    endtask : pix

    // Main sequence
    initial begin
        {rst, pd_n, pclk, swing, edge_sel, emph} = 8'hc8;
        {v_sync, h_sync, d_en, data} = 27'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata} = 40'h0;
        n_fail = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        chk("ser_rst", {ser_p, ser_n}, 2'h3);
        chk("sleep_rst", sleeping, 1'b1);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        axr(CTRL_OFF);
        chk("ctrl_rst", rd_v, CTRL_RESET);
        axr(4'hc);
        chk("unmapped", rsp, RESP_SLV);
        chk("unmapped_rd", rd_v, 32'h0);
        axw(4'hc, 32'h1);
        chk("unmapped_wr", rsp, RESP_SLV);
        $display("done reset");
        repeat (LOCK_EDGES + 1) pix(27'h0, 1'b0);
        chk("locked", sleeping, 1'b0);
        chk("no_train", rx_frames, 0);
        axr(STATUS_OFF);
        chk("status", rd_v, 32'h4);
        foreach (rows[i]) begin
            pix(rows[i][53:27], 1'b0);
            chk("rx_word", rx_word, rows[i][26:0]);
            chk("frame_word", frame_word, i_rx.sh);
        end
        chk("pair", pair_err, 0);
        chk("emph_off", emph_act, 1'b0);
        axr(FRAMES_OFF);
        chk("frames", rd_v, 5);
        $display("done rows");
        edge_sel <= 1'b0;
        pix(27'h5555555, 1'b1);
        chk("fall_cap", rx_word, 27'h5555555);
        edge_sel <= 1'b1;
        $display("done edge");
        for (int c = 0; c < 8; c++) begin
            axw(CTRL_OFF, 32'h30 | (c << 1) | (c & 1));
            repeat (2) @(posedge clk);
            chk("emph", emph_set, (c > 4) ? 0 : c);
            chk("swing", swing_hi, c & 1);
        end
        axw(CTRL_OFF, 32'h10);
        swing <= 1'b1;
        emph  <= 3'h2;
        repeat (3) @(posedge clk);
        chk("pin_emph", emph_set, 3'h2);
        chk("pin_swing", swing_hi, 1'b1);
        $display("done conditioning");
        axw(CTRL_OFF, 32'h35);
        repeat (STOP + 10) @(posedge clk);
        chk("sleep", sleeping, 1'b1);
        chk("ser_sleep", {ser_p, ser_n}, 2'h3);
        axr(CTRL_OFF);
        chk("ctrl_kept", rd_v, 32'h35);
        repeat (LOCK_EDGES + 1) pix(27'h0, 1'b0);
        pix(27'h3141592, 1'b0);
        chk("resume", rx_word, 27'h3141592);
        chk("emph_hold", emph_act, 1'b1);
        $display("done sleep");
        pd_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("ser_pd", {ser_p, ser_n}, 2'h3);
        pd_n <= 1'b1;
        repeat (2) @(posedge clk);
        axr(CTRL_OFF);
        chk("ctrl_pd", rd_v, CTRL_RESET);
        $display("done power down");
        finish_test();
    end
endmodule : parallel_to_serial_link_transmitter_bench
